// *** src/csr_amp_cv_regs.sv ***
// Current amplitude configuration and zero degree coil voltage registers
// Functional notes
// - Address 0x08 selects the current amplitude configuration register with hold and run fields.
// - The hold amplitude field is 4 bits at bits 15 to 12, writable and readable.
// - In hold operation the current reference full scale follows the hold amplitude field.
// - The run amplitude field is 4 bits at bits 4 to 1, writable and readable.
// - In run operation the current reference full scale follows the run amplitude field.
// - Address 0x09 returns the read-only 10-bit zero degree coil voltage at bits 10 to 1.
// - The zero degree result is loaded with an average taken during the phase zero microstep.
// - The 10-bit result code is scaled so that full scale equals 28 V supply.
// - Coil voltage is captured only while the capture enable bit is set.
// - The 2-bit latest update pointer reads 00 when the zero degree result was updated last.
`timescale 1ns/1ps
module csr_amp_cv_regs
  import csr_pkg::*;
#(
  parameter int PHASE_W = PHASE_W_DEF,
  parameter int AVG_LOG2 = AVG_LOG2_DEF,
  parameter logic PARITY_ODD = PARITY_ODD_DEF
) (
  // Clock and control
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  // Register access from the serial frame decoder
  input wire logic acc_valid,
  input wire logic acc_write,
  input wire logic [ADDR_W-1:0] acc_addr,
  input wire logic [DATA_W-1:0] acc_wdata,
  output logic [DATA_W-1:0] acc_rdata,
  output logic acc_rvalid,
  output logic acc_parity_err,
  // Motor state inputs
  input wire logic hold_mode,
  input wire logic capture_enable_bit,
  input wire logic [PHASE_W-1:0] phase_count,
  // Coil voltage converter samples
  input wire logic [CV_W-1:0] adc_sample,
  input wire logic adc_sample_valid,
  // Updates of the other coil voltage results
  input wire logic other_update,
  input wire logic [PTR_W-1:0] other_ptr,
  // Outputs toward current generator and control logic
  output logic [HOLD_W-1:0] full_scale_sel,
  output logic [HOLD_W-1:0] hold_amplitude_sel,
  output logic [RUN_W-1:0] run_amplitude_sel,
  output logic [CV_W-1:0] coil_voltage_result,
  output logic [PTR_W-1:0] latest_update_pointer,
  output logic cv_update
);

  // ==========================================================
  // Parity helper
  function automatic logic frame_parity(input logic [DATA_W-1:1] w);
    frame_parity = (^w) ^ PARITY_ODD;
  endfunction : frame_parity

  // ==========================================================
  // Declarations
  logic [HOLD_W-1:0] hold_q, hold_d;
  logic [RUN_W-1:0] run_q, run_d;
  logic [CV_W-1:0] cv_q, cv_d;
  logic [PTR_W-1:0] ptr_q, ptr_d;
  logic cv_upd_q, cv_upd_d;
  logic [DATA_W-1:0] rdata_q, rdata_d;
  logic rvalid_q, rvalid_d;
  logic perr_q, perr_d;
  logic [HOLD_W-1:0] fs_q, fs_d;
  logic [DATA_W-1:0] amp_word;
  logic [DATA_W-1:0] cv_word;
  logic wr_parity_ok;
  logic wr_amp;

  csr_avg_if avg_bus ();

  // ==========================================================
  // Averager link
  assign avg_bus.sample = adc_sample;
  assign avg_bus.sample_valid = adc_sample_valid;
  assign avg_bus.window = (phase_count == PHASE_W'(PHASE_ZERO));
  assign avg_bus.enable = capture_enable_bit;

  csr_averager #(
    .AVG_LOG2(AVG_LOG2)
  ) u_avg (
    .clk(clk),
    .reset(reset),
    .ce(ce),
    .bus(avg_bus)
  );

  // ==========================================================
  // Read images
  always_comb begin
    amp_word = AMP_CFG_RST;
    amp_word[HOLD_LSB +: HOLD_W] = hold_q;
    amp_word[RUN_LSB +: RUN_W] = run_q;
    amp_word[PAR_BIT] = frame_parity(amp_word[DATA_W-1:1]);
  end

  always_comb begin
    cv_word = CV_ZERO_RST;
    cv_word[CV_LSB +: CV_W] = cv_q;
    cv_word[PAR_BIT] = frame_parity(cv_word[DATA_W-1:1]);
  end

  // ==========================================================
  // Write decode
  // Frames with bad parity are not applied
  always_comb begin
    wr_parity_ok = (acc_wdata[PAR_BIT] == frame_parity(acc_wdata[DATA_W-1:1]));
    wr_amp = acc_valid && acc_write && wr_parity_ok && (acc_addr == ADDR_AMP_CFG);
  end

  // ==========================================================
  // Amplitude configuration
  always_comb begin
    hold_d = hold_q;
    run_d = run_q;
    if (wr_amp) begin
      hold_d = acc_wdata[HOLD_LSB +: HOLD_W];
      run_d = acc_wdata[RUN_LSB +: RUN_W];
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      hold_q <= HOLD_RST;
      run_q <= RUN_RST;
    end else if (ce) begin
      hold_q <= hold_d;
      run_q <= run_d;
    end
  end

  // ==========================================================
  // Full scale selection for the current reference generator
  always_comb begin
    if (hold_mode) begin
      fs_d = hold_q;
    end else begin
      fs_d = HOLD_W'(run_q);
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      fs_q <= RUN_RST;
    end else if (ce) begin
      fs_q <= fs_d;
    end
  end

  // ==========================================================
  // Zero degree result and latest update pointer
  // Own result wins over another result in the same cycle
  always_comb begin
    cv_d = cv_q;
    ptr_d = ptr_q;
    cv_upd_d = 1'b0;
    if (avg_bus.result_valid) begin
      cv_d = avg_bus.result;
      ptr_d = PTR_ZERO_DEG;
      cv_upd_d = 1'b1;
    end else if (other_update) begin
      ptr_d = other_ptr;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      cv_q <= CV_RST;
      ptr_q <= PTR_ZERO_DEG;
      cv_upd_q <= 1'b0;
    end else if (ce) begin
      cv_q <= cv_d;
      ptr_q <= ptr_d;
      cv_upd_q <= cv_upd_d;
    end
  end

  // ==========================================================
  // Read answer
  // Every frame returns contents before its own write
  always_comb begin
    rdata_d = rdata_q;
    rvalid_d = 1'b0;
    perr_d = 1'b0;
    if (acc_valid) begin
      rvalid_d = 1'b1;
      perr_d = acc_write && !wr_parity_ok;
      case (acc_addr)
        ADDR_AMP_CFG: begin
          rdata_d = amp_word;
        end
        ADDR_CV_ZERO: begin
          rdata_d = cv_word;
        end
        default: begin
          rdata_d = '0;
          rdata_d[PAR_BIT] = frame_parity(rdata_d[DATA_W-1:1]);
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      rdata_q <= '0;
      rvalid_q <= 1'b0;
      perr_q <= 1'b0;
    end else if (ce) begin
      rdata_q <= rdata_d;
      rvalid_q <= rvalid_d;
      perr_q <= perr_d;
    end
  end

  // ==========================================================
  // Outputs
  assign acc_rdata = rdata_q;
  assign acc_rvalid = rvalid_q;
  assign acc_parity_err = perr_q;
  assign full_scale_sel = fs_q;
  assign hold_amplitude_sel = hold_q;
  assign run_amplitude_sel = run_q;
  assign coil_voltage_result = cv_q;
  assign latest_update_pointer = ptr_q;
  assign cv_update = cv_upd_q;

endmodule : csr_amp_cv_regs

// *** src/csr_pkg.sv ***
// Package with register map, field layout and constants of the current scale and coil voltage slice
package csr_pkg;

  // ==========================================================
  // Frame and register map
  localparam int DATA_W = 16;
  localparam int ADDR_W = 6;
  localparam logic [ADDR_W-1:0] ADDR_AMP_CFG = 6'h08;
  localparam logic [ADDR_W-1:0] ADDR_CV_ZERO = 6'h09;
  localparam int PAR_BIT = 0;

  // ==========================================================
  // Field layout
  localparam int HOLD_LSB = 12;
  localparam int HOLD_W = 4;
  localparam int RUN_LSB = 1;
  localparam int RUN_W = 4;
  localparam int CV_LSB = 1;
  localparam int CV_W = 10;
  localparam int PTR_W = 2;

  // ==========================================================
  // Reset values and codes
  localparam logic [DATA_W-1:0] AMP_CFG_RST = 16'h0000;
  localparam logic [DATA_W-1:0] CV_ZERO_RST = 16'h0000;
  localparam logic [HOLD_W-1:0] HOLD_RST = 4'h0;
  localparam logic [RUN_W-1:0] RUN_RST = 4'h0;
  localparam logic [CV_W-1:0] CV_RST = 10'h000;
  localparam logic [PTR_W-1:0] PTR_ZERO_DEG = 2'h0;
  localparam logic PARITY_ODD_DEF = 1'b1;

  // ==========================================================
  // Measurement constants
  localparam int SUPPLY_FULL_SCALE_MV = 28000;
  localparam int PHASE_ZERO = 0;
  localparam int PHASE_W_DEF = 6;
  localparam int AVG_LOG2_DEF = 3;

  typedef enum logic [1:0] {
    CSR_AVG_IDLE = 2'b00,
    CSR_AVG_RUN = 2'b01,
    CSR_AVG_DONE = 2'b10
  } csr_avg_state_t;

endpackage : csr_pkg

// *** src/csr_avg_if.sv ***
// Interface between the register slice and its coil voltage averager
`timescale 1ns/1ps
interface csr_avg_if;
  import csr_pkg::*;
  logic [CV_W-1:0] sample;
  logic sample_valid;
  logic window;
  logic enable;
  logic [CV_W-1:0] result;
  logic result_valid;

  modport avg (
    input sample,
    input sample_valid,
    input window,
    input enable,
    output result,
    output result_valid
  );

  modport host (
    output sample,
    output sample_valid,
    output window,
    output enable,
    input result,
    input result_valid
  );
endinterface : csr_avg_if

// *** src/csr_averager.sv ***
// Averager of coil voltage samples over the zero phase microstep
`timescale 1ns/1ps
module csr_averager
  import csr_pkg::*;
#(
  parameter int AVG_LOG2 = AVG_LOG2_DEF
) (
  // Clock and control
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  // Samples in, average out
  csr_avg_if.avg bus
);

  localparam int SUM_W = CV_W + AVG_LOG2;
  localparam logic [AVG_LOG2-1:0] CNT_LAST = {AVG_LOG2{1'b1}};

  csr_avg_state_t state_q, state_d;
  logic [SUM_W-1:0] sum_q, sum_d;
  logic [AVG_LOG2-1:0] cnt_q, cnt_d;
  logic [CV_W-1:0] res_q, res_d;
  logic res_valid_q, res_valid_d;
  logic [SUM_W-1:0] sum_add;

  // ==========================================================
  // Next state
  always_comb begin
    state_d = state_q;
    sum_d = sum_q;
    cnt_d = cnt_q;
    res_d = res_q;
    res_valid_d = 1'b0;
    sum_add = sum_q + SUM_W'(bus.sample);
    case (state_q)
      CSR_AVG_IDLE: begin
        if (bus.enable && bus.window) begin
          state_d = CSR_AVG_RUN;
          sum_d = '0;
          cnt_d = '0;
        end
      end
      CSR_AVG_RUN: begin
        // Step left phase zero or capture disabled: drop partial sum
        if (!bus.enable || !bus.window) begin
          state_d = CSR_AVG_IDLE;
        end else if (bus.sample_valid) begin
          sum_d = sum_add;
          cnt_d = cnt_q + 1'b1;
          if (cnt_q == CNT_LAST) begin
            // Mean of 2^AVG_LOG2 samples never exceeds the 28 V code
            res_d = sum_add[AVG_LOG2 +: CV_W];
            res_valid_d = 1'b1;
            state_d = CSR_AVG_DONE;
          end
        end
      end
      CSR_AVG_DONE: begin
        // One result per microstep
        if (!bus.window) begin
          state_d = CSR_AVG_IDLE;
        end
      end
      default: begin
        state_d = CSR_AVG_IDLE;
      end
    endcase
  end

  // ==========================================================
  // Registers
  always_ff @(posedge clk) begin
    if (reset) begin
      state_q <= CSR_AVG_IDLE;
      sum_q <= '0;
      cnt_q <= '0;
      res_q <= CV_RST;
      res_valid_q <= 1'b0;
    end else if (ce) begin
      state_q <= state_d;
      sum_q <= sum_d;
      cnt_q <= cnt_d;
      res_q <= res_d;
      res_valid_q <= res_valid_d;
    end
  end

  assign bus.result = res_q;
  assign bus.result_valid = res_valid_q;

endmodule : csr_averager

// *** bench/csr_amp_cv_regs_assertions.sv ***
// Concurrent checks on the ports of the current scale and coil voltage slice
`timescale 1ns/1ps
module csr_amp_cv_regs_assertions
  import csr_pkg::*;
#(
  parameter int PHASE_W = PHASE_W_DEF,
  parameter logic PARITY_ODD = PARITY_ODD_DEF
) (
  // Clock and control
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  // Register access
  input wire logic acc_valid,
  input wire logic acc_write,
  input wire logic [ADDR_W-1:0] acc_addr,
  input wire logic [DATA_W-1:0] acc_wdata,
  input wire logic [DATA_W-1:0] acc_rdata,
  input wire logic acc_rvalid,
  input wire logic acc_parity_err,
  // Motor state
  input wire logic hold_mode,
  input wire logic capture_enable_bit,
  input wire logic [PHASE_W-1:0] phase_count,
  // Outputs
  input wire logic [HOLD_W-1:0] full_scale_sel,
  input wire logic [HOLD_W-1:0] hold_amplitude_sel,
  input wire logic [RUN_W-1:0] run_amplitude_sel,
  input wire logic [CV_W-1:0] coil_voltage_result,
  input wire logic [PTR_W-1:0] latest_update_pointer,
  input wire logic cv_update
);
  // ==========================================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  logic good_wr;
  assign good_wr = ce && acc_valid && acc_write && acc_addr == ADDR_AMP_CFG
    && (^acc_wdata) == PARITY_ODD;

  answer_next_a: assert property (ce && acc_valid |=> acc_rvalid)
    else $error("access not answered one cycle later");
  answer_cause_a: assert property (acc_rvalid |-> $past(ce && acc_valid))
    else $error("answer without access");
  hold_write_a: assert property (good_wr |=> hold_amplitude_sel == $past(acc_wdata[15:12]))
    else $error("hold field not written");
  run_write_a: assert property (good_wr |=> run_amplitude_sel == $past(acc_wdata[4:1]))
    else $error("run field not written");
  scale_pick_a: assert property (ce |=> full_scale_sel == ($past(hold_mode) ?
    $past(hold_amplitude_sel) : $past(run_amplitude_sel)))
    else $error("full scale selection wrong");
  read_parity_a: assert property (acc_rvalid |-> (^acc_rdata) == PARITY_ODD)
    else $error("read word parity wrong");
  cv_reserved_a: assert property (acc_rvalid && $past(acc_addr) == ADDR_CV_ZERO
    |-> acc_rdata[15:11] == 5'h00)
    else $error("coil voltage reserved bits set");
  perr_pair_a: assert property (acc_parity_err |-> acc_rvalid)
    else $error("parity error without answer");
  update_ptr_a: assert property (cv_update |-> latest_update_pointer == PTR_ZERO_DEG)
    else $error("pointer not zero after update");
  capture_cause_a: assert property (cv_update |-> $past(phase_count, 2) == '0
    && $past(capture_enable_bit, 2))
    else $error("result loaded outside enabled zero window");
  result_hold_a: assert property (!cv_update |-> $stable(coil_voltage_result))
    else $error("result changed without update");
endmodule : csr_amp_cv_regs_assertions

// *** bench/csr_host_model.sv ***
// Host model that issues register access frames
`timescale 1ns/1ps
module csr_host_model
  import csr_pkg::*;
#(
  parameter logic PARITY_ODD = PARITY_ODD_DEF
) (
  // Clock
  input wire logic clk,
  // Frame out
  output logic acc_valid,
  output logic acc_write,
  output logic [ADDR_W-1:0] acc_addr,
  output logic [DATA_W-1:0] acc_wdata,
  // Answer in
  input wire logic [DATA_W-1:0] acc_rdata,
  input wire logic acc_rvalid,
  input wire logic acc_parity_err
);
  initial begin
    acc_valid = 1'b0;
    acc_write = 1'b0;
    acc_addr = '0;
    acc_wdata = '0;
  end
  function automatic logic [DATA_W-1:0] par(input logic [DATA_W-1:0] w);
    par = {w[DATA_W-1:1], (^w[DATA_W-1:1]) ^ PARITY_ODD};
  endfunction : par
  task automatic xfer(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
      output logic [17:0] ans);
    @(posedge clk);
    #1;
    acc_valid = 1'b1;
    acc_write = w;
    acc_addr = a;
    acc_wdata = d;
    @(posedge clk);
    #1;
    acc_valid = 1'b0;
    // Released bus shows no stale word
    acc_wdata = ~d;
    acc_addr = ~a;
    ans = {acc_rvalid, acc_parity_err, acc_rdata};
  endtask : xfer
endmodule : csr_host_model

// *** bench/csr_amp_cv_regs_test.sv ***
// Testbench of the current scale and coil voltage slice
`timescale 1ns/1ps
module csr_amp_cv_regs_test;
  import csr_pkg::*;
  logic clk = 1'b0, reset = 1'b1, ce = 1'b1, hold_mode = 1'b0, cen = 1'b0;
  logic acc_valid, acc_write, acc_rvalid, acc_parity_err, cv_update;
  logic adc_valid = 1'b0, oth_upd = 1'b0;
  logic [ADDR_W-1:0] acc_addr;
  logic [DATA_W-1:0] acc_wdata, acc_rdata, prev;
  logic [5:0] phase = 6'h01;
  logic [CV_W-1:0] adc = '0, cvr;
  logic [PTR_W-1:0] oth_ptr = '0, ptr;
  logic [3:0] fs, hs, rs;
  logic [17:0] ans;
  int err_count = 0, checked = 0;

  csr_amp_cv_regs dut (.clk(clk), .reset(reset), .ce(ce), .acc_valid(acc_valid),
    .acc_write(acc_write), .acc_addr(acc_addr), .acc_wdata(acc_wdata), .acc_rdata(acc_rdata),
    .acc_rvalid(acc_rvalid), .acc_parity_err(acc_parity_err), .hold_mode(hold_mode),
    .capture_enable_bit(cen), .phase_count(phase), .adc_sample(adc),
    .adc_sample_valid(adc_valid), .other_update(oth_upd), .other_ptr(oth_ptr),
    .full_scale_sel(fs), .hold_amplitude_sel(hs), .run_amplitude_sel(rs),
    .coil_voltage_result(cvr), .latest_update_pointer(ptr), .cv_update(cv_update));
  csr_host_model host (.clk(clk), .acc_valid(acc_valid), .acc_write(acc_write),
    .acc_addr(acc_addr), .acc_wdata(acc_wdata), .acc_rdata(acc_rdata),
    .acc_rvalid(acc_rvalid), .acc_parity_err(acc_parity_err));

  initial begin
    forever #4 clk = ~clk;
  end

  task automatic check(input string name, input logic [17:0] seen, input logic [17:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic acc(input logic w, input logic [5:0] a, input logic [15:0] d,
      input logic pe, input logic [15:0] exp);
    host.xfer(w, a, d, ans);
    check("answer", ans, {1'b1, pe, exp});
  endtask : acc
  // One zero phase window with n samples base, base+1, ...
  task automatic cap(input int n, input logic en, input logic [9:0] base);
    @(posedge clk);
    #1;
    phase = 6'h00;
    cen = en;
    for (int k = 0; k < n; k++) begin
      @(posedge clk);
      #1;
      adc_valid = 1'b1;
      adc = base + k[9:0];
    end
    @(posedge clk);
    #1;
    adc_valid = 1'b0;
    adc = ~adc;
    repeat (3) @(posedge clk);
    #1;
    phase = 6'h01;
    cen = 1'b0;
  endtask : cap
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : finish_test

  initial begin
    #100us;
    err_count++;
    finish_test();
  end

  initial begin
    repeat (5) @(posedge clk);
    #1;
    reset = 1'b0;
    acc(1'b0, ADDR_AMP_CFG, 16'h0000, 1'b0, host.par(16'h0000));
    acc(1'b0, ADDR_CV_ZERO, 16'h0000, 1'b0, host.par(16'h0000));
    acc(1'b0, 6'h3F, 16'h0000, 1'b0, 16'h0001);
    prev = host.par(16'h0000);
    for (int i = 0; i < 16; i++) begin
      acc(1'b1, ADDR_AMP_CFG, host.par({i[3:0], 7'h7F, ~i[3:0], 1'b0}), 1'b0, prev);
      prev = host.par({i[3:0], 7'h00, ~i[3:0], 1'b0});
      check("hold_run", {hs, rs}, {i[3:0], ~i[3:0]});
    end
    hold_mode = 1'b1;
    repeat (2) @(posedge clk);
    #1;
    check("fs_hold", fs, 4'hF);
    hold_mode = 1'b0;
    repeat (2) @(posedge clk);
    #1;
    check("fs_run", fs, 4'h0);
    // Only the parity bit flipped, so the frame is refused
    acc(1'b1, ADDR_AMP_CFG, host.par(16'h1234) ^ 16'h0001, 1'b1, prev);
    acc(1'b1, ADDR_CV_ZERO, host.par(16'h07FE), 1'b0, host.par(16'h0000));
    acc(1'b0, ADDR_CV_ZERO, 16'h0000, 1'b0, host.par(16'h0000));
    @(posedge clk);
    #1 oth_upd = 1'b1;
    oth_ptr = 2'h3;
    @(posedge clk);
    #1 oth_upd = 1'b0;
    check("ptr_other", ptr, 2'h3);
    // Clock enable low freezes the pointer against another update
    @(posedge clk);
    #1 ce = 1'b0;
    oth_upd = 1'b1;
    oth_ptr = 2'h1;
    @(posedge clk);
    #1 oth_upd = 1'b0;
    check("ptr_frozen", ptr, 2'h3);
    ce = 1'b1;
    @(posedge clk);
    #1;
    check("ptr_thawed", ptr, 2'h3);
    cap(8, 1'b1, 10'h1BF);
    check("cv", {cvr, ptr}, {10'h1C2, 2'h0});
    acc(1'b0, ADDR_CV_ZERO, 16'h0000, 1'b0, host.par({5'h00, 10'h1C2, 1'b0}));
    cap(4, 1'b1, 10'h064);
    check("cv_short", cvr, 10'h1C2);
    cap(8, 1'b0, 10'h064);
    check("cv_off", cvr, 10'h1C2);
    finish_test();
  end
endmodule : csr_amp_cv_regs_test

bind csr_amp_cv_regs csr_amp_cv_regs_assertions #(.PHASE_W(PHASE_W), .PARITY_ODD(PARITY_ODD))
  chk_i (.clk(clk), .reset(reset), .ce(ce), .acc_valid(acc_valid), .acc_write(acc_write),
  .acc_addr(acc_addr), .acc_wdata(acc_wdata), .acc_rdata(acc_rdata), .acc_rvalid(acc_rvalid),
  .acc_parity_err(acc_parity_err), .hold_mode(hold_mode),
  .capture_enable_bit(capture_enable_bit), .phase_count(phase_count),
  .full_scale_sel(full_scale_sel), .hold_amplitude_sel(hold_amplitude_sel),
  .run_amplitude_sel(run_amplitude_sel), .coil_voltage_result(coil_voltage_result),
  .latest_update_pointer(latest_update_pointer), .cv_update(cv_update));
